// ---- core/ias_consts.svh ----
// Purpose: constants for the indirect address sequencer
// Assumes: 16-bit address bus, 8-bit data bus
// Notes: opcode encodings are the ones common to this processor family
`ifndef IAS_CONSTS_SVH
`define IAS_CONSTS_SVH
`define IAS_ZP_HIGH 8'h00
`define IAS_PROG_BYTES 16'h0002
`define IAS_OP_INCLUSIVE_OR 3'h0
`define IAS_OP_AND 3'h1
`define IAS_OP_EXCLUSIVE_OR 3'h2
`define IAS_OP_ADC 3'h3
`define IAS_OP_STORE_ACCUMULATOR 3'h4
`define IAS_OP_LOAD_ACCUMULATOR 3'h5
`define IAS_OP_COMPARE_ACCUMULATOR 3'h6
`define IAS_OP_SUBTRACT_WITH_BORROW 3'h7
`define IAS_CC_ALU 2'h1
`define IAS_CC_RMW 2'h2
`define IAS_CC_IDX 2'h0
`define IAS_MODE_XIND 3'h0
`define IAS_MODE_ZPX 3'h5
`define IAS_MODE_INDY 3'h4
`define IAS_OP_SHIFT_LEFT 3'h0
`define IAS_OP_ROTATE_LEFT 3'h1
`define IAS_OP_SHIFT_RIGHT 3'h2
`define IAS_OP_STORE_FIRST_INDEX 3'h4
`define IAS_OP_LOAD_FIRST_INDEX 3'h5
`define IAS_OP_DECREMENT_MEMORY 3'h6
`define IAS_OP_INC 3'h7
`define IAS_OP_STORE_SECOND_INDEX 3'h4
`define IAS_OP_LOAD_SECOND_INDEX 3'h5
`endif

// ---- core/ias_pkg.sv ----
// Purpose: types for the indirect address sequencer
// Assumes: nothing
// Notes: state codes are binary
package ias_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PTR = 4'h1,
      ST_DUMMY = 4'h2,
      ST_LOW = 4'h3,
      ST_HIGH = 4'h4,
      ST_FIX = 4'h5,
      ST_OPER = 4'h6,
      ST_WRITE = 4'h7,
      ST_BAD = 4'h8
   } state_e;
   typedef enum logic [1:0] {
      MD_ZPI = 2'h0,
      MD_XIND = 2'h1,
      MD_INDY = 2'h2,
      MD_NONE = 2'h3
   } mode_e;
endpackage

// ---- core/ias_decode.sv ----
// Purpose: classify an opcode into one of the three addressing modes, or MD_NONE for any other opcode
// Assumes: opcode bit fields aaa-bbb-cc
// Notes: combinational only
`timescale 1ns/100ps
`default_nettype none
`include "ias_consts.svh"
module ias_decode (
   input wire logic [7:0] i_opcode, // Opcode byte
   output ias_pkg::mode_e o_mode, // Addressing mode
   output logic o_use_second, // Index with the second register
   output logic o_is_write, // Store operation
   output logic o_is_rmw // Read-modify-write operation
);
   wire [2:0] aaa = i_opcode[7:5];
   wire [2:0] bbb = i_opcode[4:2];
   wire [1:0] cc = i_opcode[1:0];
   wire alu_grp = (cc == `IAS_CC_ALU);
   wire rmw_grp = (cc == `IAS_CC_RMW);
   wire idx_grp = (cc == `IAS_CC_IDX);
   // Zero-page indexed opcodes; store/load of first index go via second index
   wire zpi_alu = alu_grp && (bbb == `IAS_MODE_ZPX);
   wire zpi_rmw = rmw_grp && (bbb == `IAS_MODE_ZPX);
   wire zpi_idx = idx_grp && (bbb == `IAS_MODE_ZPX) &&
      (aaa == `IAS_OP_STORE_SECOND_INDEX || aaa == `IAS_OP_LOAD_SECOND_INDEX);
   wire zpi_any = zpi_alu || zpi_rmw || zpi_idx; // see (RL3)
   wire xind = alu_grp && (bbb == `IAS_MODE_XIND); // see (RL11)
   wire indy = alu_grp && (bbb == `IAS_MODE_INDY);
   // Mode selection
   assign o_mode = zpi_any ? ias_pkg::MD_ZPI : xind ? ias_pkg::MD_XIND : indy ? ias_pkg::MD_INDY : ias_pkg::MD_NONE;
   wire first_index_move = (aaa == `IAS_OP_STORE_FIRST_INDEX || aaa == `IAS_OP_LOAD_FIRST_INDEX);
   assign o_use_second = zpi_rmw && first_index_move; // see (RL2)
   assign o_is_write = (alu_grp && aaa == `IAS_OP_STORE_ACCUMULATOR) ||
      (zpi_rmw && aaa == `IAS_OP_STORE_FIRST_INDEX) || (zpi_idx && aaa == `IAS_OP_STORE_SECOND_INDEX);
   assign o_is_rmw = zpi_rmw && !first_index_move;
endmodule // ias_decode
`default_nettype wire

// ---- core/ias_seq.sv ----
// Purpose: address generation and bus sequencing for zero-page indexed and indirect modes
// Assumes: one bus access per cycle; memory answers reads in the same cycle
// Notes: the caller fetches the opcode and presents it with i_start in cycle 1
`timescale 1ns/100ps
`default_nettype none
`include "ias_consts.svh"
// How it works
// (RL1) Zero-page base plus first index wraps within zero page, no extra cycle.
// (RL2) Zero-page indexing uses first index, except first-index load/store use second.
// (RL3) Zero-page first-index mode offered for the listed arithmetic, shift and move ops.
// (RL4) Byte after opcode is a zero-page pointer; target low read from it.
// (RL5) Pointer plus one gives the location of the target high byte.
// (RL6) Cycle after high fetch puts assembled target address on the bus.
// (RL7) Indexed indirect adds first index to pointer; cycle 3 reads unindexed pointer.
// (RL8) Indexed indirect always takes six cycles.
// (RL9) Indexed pointer sums wrap in zero page, never carry to high byte.
// (RL10) Indexed indirect cycles three and four use high address byte zero.
// (RL11) Indexed indirect offered only for the eight accumulator operations.
// (RL12) Indirect indexed fetches base pair, then adds second index.
// (RL13) Without page crossing indirect indexed reads operand in cycle 5.
// (RL14) A low-byte carry adds a cycle to bump the base high byte.
// (RL15) Both indirect modes use two program bytes; PC advances by two.
// (RL16) Zero-page indexed accesses force the high address byte to zero.
// (RL17) Accesses to uncorrected addresses are reads; writes wait for the true address.
// (RL18) Indirect indexed stores and RMW always take the crossing path.
// (RL19) Pointer at last zero-page byte takes high byte from location zero.
// (RL20) Discarded reads strobe like normal reads; their data is ignored.
module ias_seq (
   input wire logic i_clk, // 200 MHz clock
   input wire logic i_rst, // Async reset, active high
   input wire logic i_start, // Opcode present, cycle 1
   input wire logic [7:0] i_opcode, // Opcode byte
   input wire logic [15:0] i_pc, // Address of the opcode
   input wire logic [7:0] i_index_x, // First index register
   input wire logic [7:0] i_index_y, // Second index register
   input wire logic [7:0] i_rdata, // Memory read data
   input wire logic [7:0] i_wdata, // Store or modified data
   output logic [15:0] o_addr, // Address bus
   output logic o_rd, // Read strobe
   output logic o_wr, // Write strobe
   output logic [7:0] o_wdata, // Write data
   output logic o_busy, // Sequence in progress
   output logic o_operand_valid, // Operand read this cycle
   output logic [7:0] o_operand, // Captured operand
   output logic o_done, // Last cycle of the sequence
   output logic [15:0] o_next_pc, // Program counter after operand
   output logic o_unsupported // Opcode not in these modes
);
   ias_pkg::state_e state_q, state_d;
   ias_pkg::mode_e mode_w, mode_q;
   logic use_second_w, is_write_w, is_rmw_w;
   logic use_second_q, is_write_q, is_rmw_q;
   logic [15:0] pc_q;
   logic [7:0] pointer_byte_q, target_low_byte_q, target_high_byte_q, operand_q;
   logic carry_q, started_q;

   // Opcode classification
   // Opcodes outside these modes leave the sequencer idle and raise o_unsupported
   ias_decode u_decode (
      .i_opcode(i_opcode),
      .o_mode(mode_w),
      .o_use_second(use_second_w),
      .o_is_write(is_write_w),
      .o_is_rmw(is_rmw_w)
   );

   // Index selection and zero-page sums; 8-bit width gives the wrap for free
   // X for indexed indirect; zero-page first-index load/store select the second index
   wire [7:0] zp_index = use_second_q ? i_index_y : i_index_x; // see (RL2)
   wire [7:0] zp_sum = pointer_byte_q + zp_index; // see (RL1) (RL9)
   // Pointer plus one wraps too, so a pair at the top of zero page ends at location zero
   wire [7:0] ptr_next = pointer_byte_q + 8'h01; // see (RL5) (RL19)
   wire [8:0] low_sum = {1'b0, target_low_byte_q} + {1'b0, i_index_y}; // see (RL12)
   wire [7:0] high_fixed = target_high_byte_q + 8'h01; // see (RL14)
   wire writes = is_write_q || is_rmw_q;
   wire in_xind = (mode_q == ias_pkg::MD_XIND);
   wire in_zpi = (mode_q == ias_pkg::MD_ZPI);
   wire in_indy = (mode_q == ias_pkg::MD_INDY);

   // Next-state logic
   always_comb begin
      state_d = state_q;
      case (state_q)
         ias_pkg::ST_IDLE: begin
            if (i_start && mode_w != ias_pkg::MD_NONE) begin
               state_d = ias_pkg::ST_PTR;
            end
         end
         ias_pkg::ST_PTR: begin
            state_d = in_indy ? ias_pkg::ST_LOW : ias_pkg::ST_DUMMY; // see (RL4)
         end
         ias_pkg::ST_DUMMY: begin
            state_d = in_zpi ? ias_pkg::ST_OPER : ias_pkg::ST_LOW; // see (RL7)
         end
         ias_pkg::ST_LOW: begin
            state_d = ias_pkg::ST_HIGH;
         end
         // Indirect indexed stores take the fix cycle even without carry, so no write hits a false address
         ias_pkg::ST_HIGH: begin
            if (in_indy && (low_sum[8] || writes)) begin
               state_d = ias_pkg::ST_FIX; // see (RL14) (RL18)
            end else begin
               state_d = ias_pkg::ST_OPER; // see (RL6) (RL8) (RL13)
            end
         end
         ias_pkg::ST_FIX: begin
            state_d = ias_pkg::ST_OPER;
         end
         // Read-modify-write adds one write cycle at the same address
         ias_pkg::ST_OPER: begin
            state_d = is_rmw_q ? ias_pkg::ST_WRITE : ias_pkg::ST_IDLE;
         end
         ias_pkg::ST_WRITE: begin
            state_d = ias_pkg::ST_IDLE;
         end
         default: begin
            state_d = ias_pkg::ST_IDLE;
         end
      endcase
   end

   // Address bus; every zero-page access carries the zero high byte
   wire at_ptr = (state_q == ias_pkg::ST_PTR);
   wire at_dummy = (state_q == ias_pkg::ST_DUMMY);
   wire at_low = (state_q == ias_pkg::ST_LOW);
   wire at_high = (state_q == ias_pkg::ST_HIGH);
   wire at_fix = (state_q == ias_pkg::ST_FIX);
   wire at_final = (state_q == ias_pkg::ST_OPER) || (state_q == ias_pkg::ST_WRITE);
   wire [15:0] pc_after = pc_q + 16'h0001; // Pointer byte follows the opcode
   // Indexed indirect pointer already holds the indexed sum after the dummy cycle
   wire [15:0] zp_ptr_addr = {`IAS_ZP_HIGH, pointer_byte_q}; // see (RL16)
   wire [15:0] zp_sum_addr = {`IAS_ZP_HIGH, zp_sum}; // see (RL1) (RL16)
   wire [15:0] zp_next_addr = {`IAS_ZP_HIGH, ptr_next}; // see (RL5) (RL10)
   wire [15:0] target_addr = {target_high_byte_q, target_low_byte_q}; // see (RL6)
   wire [15:0] fixed_addr = {high_fixed, target_low_byte_q}; // see (RL14)
   assign o_addr = at_ptr ? pc_after :
                   at_dummy ? zp_ptr_addr : // see (RL7)
                   at_low ? zp_ptr_addr : // see (RL4) (RL10)
                   at_high ? zp_next_addr :
                   at_fix ? target_addr : // see (RL17)
                   (at_final && in_zpi) ? zp_sum_addr :
                   (at_final && carry_q) ? fixed_addr :
                   at_final ? target_addr : 16'h0000;

   // Strobes; dummy and fix cycles are plain reads, writes only at the true address
   wire active = (state_q != ias_pkg::ST_IDLE);
   wire write_now = (state_q == ias_pkg::ST_OPER && is_write_q) || (state_q == ias_pkg::ST_WRITE);
   assign o_wr = write_now; // see (RL17) (RL18)
   assign o_rd = active && !write_now; // see (RL20)
   // Busy drops in the cycle after o_done, so a new start may follow at once
   assign o_busy = active;
   assign o_operand_valid = (state_q == ias_pkg::ST_OPER) && !is_write_q;
   assign o_done = (state_q == ias_pkg::ST_OPER && !is_rmw_q) || (state_q == ias_pkg::ST_WRITE);
   assign o_wdata = i_wdata;
   assign o_operand = operand_q;
   assign o_next_pc = pc_q + `IAS_PROG_BYTES; // see (RL15)
   assign o_unsupported = started_q;

   // State and captured bytes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ias_pkg::ST_IDLE;
         mode_q <= ias_pkg::MD_NONE;
         use_second_q <= 1'b0;
         is_write_q <= 1'b0;
         is_rmw_q <= 1'b0;
         pc_q <= 16'h0000;
         started_q <= 1'b0;
      end else begin
         state_q <= state_d;
         started_q <= (state_q == ias_pkg::ST_IDLE) && i_start && (mode_w == ias_pkg::MD_NONE);
         // Latch the decode once; the opcode input may change after cycle 1
         if (state_q == ias_pkg::ST_IDLE && i_start) begin
            mode_q <= mode_w;
            use_second_q <= use_second_w;
            is_write_q <= is_write_w;
            is_rmw_q <= is_rmw_w;
            pc_q <= i_pc;
         end
      end
   end

   // Datapath bytes; the discarded byte is never loaded
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pointer_byte_q <= 8'h00;
         target_low_byte_q <= 8'h00;
         target_high_byte_q <= 8'h00;
         operand_q <= 8'h00;
         carry_q <= 1'b0;
      end else begin
         if (state_q == ias_pkg::ST_PTR) begin
            pointer_byte_q <= i_rdata; // see (RL4)
         end
         if (state_q == ias_pkg::ST_DUMMY && in_xind) begin
            pointer_byte_q <= zp_sum; // see (RL7) (RL9)
         end
         if (state_q == ias_pkg::ST_LOW) begin
            target_low_byte_q <= i_rdata;
         end
         // Indirect indexed replaces the low byte with its indexed sum here,
         // so the fix cycle and the operand cycle both reuse it
         // Carry is cleared here for indexed indirect so a stale one cannot bump a later high byte
         if (state_q == ias_pkg::ST_HIGH) begin
            target_high_byte_q <= i_rdata;
            if (in_indy) begin
               target_low_byte_q <= low_sum[7:0]; // see (RL13)
            end
            carry_q <= 1'b0;
         end
         if (state_q == ias_pkg::ST_FIX) begin
            carry_q <= carry_q;
         end
         if (state_q == ias_pkg::ST_HIGH && in_indy) begin
            carry_q <= low_sum[8]; // see (RL14)
         end
         if (state_q == ias_pkg::ST_OPER && !is_write_q) begin
            operand_q <= i_rdata;
         end
      end
   end
endmodule // ias_seq
`default_nettype wire

// ---- tb/ias_seq_sva.sv ----
// Purpose: port checks for the indirect address sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes: the indexed indirect case is spotted from the opcode low bits
`timescale 1ns/100ps
`default_nettype none
module ias_seq_chk (
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_start, // Start
   input wire logic [7:0] i_opcode, // Opcode
   input wire logic [15:0] i_pc, // Opcode address
   input wire logic [7:0] i_rdata, // Read data
   input wire logic [15:0] o_addr, // Address bus
   input wire logic o_rd, // Read strobe
   input wire logic o_wr, // Write strobe
   input wire logic o_busy, // Busy
   input wire logic o_operand_valid, // Operand cycle
   input wire logic [7:0] o_operand, // Operand
   input wire logic o_done, // Last cycle
   input wire logic o_unsupported // Refused
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Accepted start, and the indexed indirect case
   wire logic go = i_start && !o_busy;
   wire logic xind = go && i_opcode[4:0] == 5'h01;
   ptr_fetch_a: assert property (go |=> o_unsupported || (o_rd && o_addr == $past(i_pc) + 16'h0001))
      else $error("pointer not fetched after opcode");
   zp_ptr_read_a: assert property (go ##1 !o_unsupported |=> o_rd && o_addr == {8'h00, $past(i_rdata)})
      else $error("third cycle not a read of the pointer");
   zp_high_a: assert property (go ##1 !o_unsupported |-> ##2 o_addr[15:8] == 8'h00)
      else $error("fourth cycle left zero page");
   xind_length_a: assert property (xind |=> !o_done [*4] ##1 o_done)
      else $error("indexed indirect not six cycles");
   xind_pair_a: assert property (xind |-> ##4 o_addr == (($past(o_addr) + 16'h0001) & 16'h00FF))
      else $error("high byte fetch not next zero-page byte");
   write_last_a: assert property (o_wr |-> o_done && !o_rd)
      else $error("write before the final cycle");
   operand_capture_a: assert property (o_operand_valid |=> o_operand == $past(i_rdata))
      else $error("operand not captured");
   seq_bound_a: assert property (go ##1 o_busy |-> ##[0:5] o_done)
      else $error("sequence too long");
endmodule // ias_seq_chk
bind ias_seq ias_seq_chk chk (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode), .i_pc(i_pc),
   .i_rdata(i_rdata), .o_addr(o_addr), .o_rd(o_rd), .o_wr(o_wr), .o_busy(o_busy), .o_operand_valid(o_operand_valid),
   .o_operand(o_operand), .o_done(o_done), .o_unsupported(o_unsupported));
`default_nettype wire

// ---- tb/ias_mem.sv ----
// Purpose: byte memory behind the sequencer bus
// Assumes: read data answers in the same cycle
// Notes: an idle data bus shows the inverse of the last byte read
`timescale 1ns/100ps
`default_nettype none
module ias_mem (
   input wire logic i_clk, // Clock
   input wire logic [15:0] i_addr, // Address bus
   input wire logic i_rd, // Read strobe
   input wire logic i_wr, // Write strobe
   input wire logic [7:0] i_wdata, // Write data
   output logic [7:0] o_rdata // Read data
);
   logic [7:0] m [65536];
   logic [7:0] last_q = 8'h00;
   // Pattern fill so stray reads show up
   initial begin
      for (int i = 0; i < 65536; i++)
         m[i] = 8'(i ^ (i >> 8) ^ 8'h5A);
   end
   // Undriven bus never repeats the last byte
   assign o_rdata = i_rd ? m[i_addr] : ~last_q;
   // Writes land at the clock edge
   always @(posedge i_clk) begin
      if (i_rd) last_q <= m[i_addr];
      if (i_wr) m[i_addr] <= i_wdata;
   end
endmodule // ias_mem
`default_nettype wire

// ---- tb/indirect_address_sequencer_bench.sv ----
// Purpose: self-checking bench for the indirect address sequencer
// Assumes: opcode at 0400, pointer byte at 0401
// Notes: expected addresses worked out by hand per scenario
`timescale 1ns/100ps
`default_nettype none
module indirect_address_sequencer_bench;
   logic clk = 1'b0, rst = 1'b1, start = 1'b0, rd, wr, busy, opv, done, unsup;
   logic [7:0] opc = 8'h00, ix = 8'h00, iy = 8'h00, wd = 8'h00, rdata, wdo, opnd;
   logic [15:0] pc = 16'h0400, addr, npc;
   int n_mismatch = 0, n_compared = 0;
   ias_seq uut (.i_clk(clk), .i_rst(rst), .i_start(start), .i_opcode(opc), .i_pc(pc), .i_index_x(ix),
      .i_index_y(iy), .i_rdata(rdata), .i_wdata(wd), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdo),
      .o_busy(busy), .o_operand_valid(opv), .o_operand(opnd), .o_done(done), .o_next_pc(npc),
      .o_unsupported(unsup));
   ias_mem mem (.i_clk(clk), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdo), .o_rdata(rdata));
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   // One instruction: length, operand address, write, next pc and data
   task automatic op(input logic [7:0] o, p, xv, yv, input logic [15:0] ea, input int nc, input logic ew);
      int n;
      logic w;
      logic [7:0] exp;
      logic [15:0] seen;
      mem.m[16'h0401] = p;
      exp = mem.m[ea];
      @(posedge clk);
      start <= 1'b1;
      opc <= o;
      ix <= xv;
      iy <= yv;
      wd <= ~exp;
      @(posedge clk);
      start <= 1'b0;
      n = 1;
      w = 1'b0;
      seen = 16'h0000;
      while (done !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
         if (opv === 1'b1 || wr === 1'b1) seen = addr;
         if (wr === 1'b1) w = 1'b1;
      end
      check(n == nc, "cycle count");
      check(seen === ea && w === ew, "operand access");
      check(npc === 16'h0402, "next pc");
      @(negedge clk);
      if (ew) check(mem.m[ea] === ~exp, "write data");
      else check(opnd === exp, "operand");
   endtask
   task automatic t_zp_index;
      op(8'hB5, 8'hF7, 8'h10, 8'h00, 16'h0007, 4, 1'b0);
      op(8'hB6, 8'h20, 8'h99, 8'h05, 16'h0025, 4, 1'b0);
      op(8'h96, 8'h20, 8'h99, 8'h06, 16'h0026, 4, 1'b1);
   endtask
   task automatic t_zpx_list;
      logic [7:0] ops [15] = '{8'h75, 8'h35, 8'h16, 8'hD5, 8'hD6, 8'h55, 8'hF6, 8'hB5, 8'hB4, 8'h56, 8'h15,
         8'h36, 8'hF5, 8'h95, 8'h94};
      logic rmw;
      foreach (ops[i]) begin
         rmw = ops[i][1:0] == 2'b10;
         op(ops[i], 8'h80, 8'h03, 8'h00, 16'h0083, rmw ? 5 : 4, rmw || ops[i][7:4] == 4'h9);
      end
   endtask
   // Pair at the top of zero page wraps to location zero
   task automatic t_xind_list;
      logic [7:0] ops [8] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h81, 8'hA1, 8'hC1, 8'hE1};
      foreach (ops[i]) op(ops[i], 8'hFE, 8'h01, 8'h00, 16'h1234, 6, ops[i] == 8'h81);
   endtask
   task automatic t_indy;
      op(8'hB1, 8'h50, 8'h00, 8'h05, 16'h2215, 5, 1'b0);
      op(8'hB1, 8'h52, 8'h00, 8'h20, 16'h2310, 6, 1'b0);
      op(8'h91, 8'h50, 8'h00, 8'h01, 16'h2211, 6, 1'b1);
      op(8'hB1, 8'hFF, 8'h00, 8'h00, 16'h1234, 5, 1'b0);
   endtask
   task automatic t_refuse;
      logic [7:0] ops [2] = '{8'hA9, 8'hA2};
      foreach (ops[i]) begin
         @(posedge clk);
         start <= 1'b1;
         opc <= ops[i];
         @(posedge clk);
         start <= 1'b0;
         @(negedge clk);
         check(unsup === 1'b1 && busy === 1'b0, "opcode not refused");
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Pointer pairs, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      mem.m[16'h00FF] = 8'h34;
      mem.m[16'h0000] = 8'h12;
      mem.m[16'h0050] = 8'h10;
      mem.m[16'h0051] = 8'h22;
      mem.m[16'h0052] = 8'hF0;
      mem.m[16'h0053] = 8'h22;
      rst <= 1'b0;
      t_zp_index();
      t_zpx_list();
      t_xind_list();
      t_indy();
      t_refuse();
      test_done();
   end
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule // indirect_address_sequencer_bench
`default_nettype wire
